// ### fre_chk.sv
// Purpose: Assertion checker for the flash row erase control.
// Assumes: Only the top ports are visible; reset is synchronous.
// Notes: Bound to the design at the foot of this file.
`timescale 1ns/1ps
module fre_chk #(
  parameter int ERASE_COUNT = 20
) (
  // Clock, reset and APB.
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash and core side.
  input wire logic abort_req,
  input wire fre_pkg::fre_flash_req_t flash_req,
  input wire logic cpu_stall,
  input wire logic irq
);
  logic wr;
  logic st_wr;
  logic [1:0] unl_q;
  logic [15:0] row_q;
  int cnt_q;
  logic ab_q;
  assign wr = psel && penable && pwrite;
  assign st_wr = wr && paddr == fre_pkg::OFF_CONTROL && pwdata[1];
  // Follows the unlock bytes; any other write disarms it.
  always_ff @(posedge mclk) begin
    if (reset) unl_q <= 2'h0;
    else if (wr && paddr == fre_pkg::OFF_UNLOCK)
      unl_q <= (pwdata[7:0] == fre_pkg::UNLOCK_FIRST) ? 2'h1 :
        (pwdata[7:0] == fre_pkg::UNLOCK_SECOND && unl_q == 2'h1) ?
        2'h2 : 2'h0;
    else if (wr) unl_q <= 2'h0;
  end
  // Keeps the row part of the pointer written while idle.
  always_ff @(posedge mclk) begin
    if (reset) row_q <= 16'h0;
    else if (wr && paddr == fre_pkg::OFF_PTR && !cpu_stall)
      row_q <= pwdata[21:6];
  end
  // Counts stall cycles and notes an abort seen inside them.
  always_ff @(posedge mclk) begin
    if (reset || !cpu_stall) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
  always_ff @(posedge mclk) begin
    if (reset || !cpu_stall) ab_q <= 1'b0;
    else if (abort_req) ab_q <= 1'b1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_pulse;
    flash_req.erase ##1 !flash_req.erase;
  endsequence
  property p_pulse;
    $rose(cpu_stall) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad pulse");
  property p_hold;
    flash_req.erase |-> cpu_stall;
  endproperty
  a_hold: assert property (p_hold) else $error("no stall");
  property p_row;
    flash_req.erase |-> flash_req.row == row_q;
  endproperty
  a_row: assert property (p_row) else $error("bad row");
  property p_unl;
    $rose(cpu_stall) |-> $past(unl_q) == 2'h2;
  endproperty
  a_unl: assert property (p_unl) else $error("not unlocked");
  property p_start;
    $rose(cpu_stall) |-> $past(st_wr);
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_max;
    cpu_stall |-> cnt_q < ERASE_COUNT;
  endproperty
  a_max: assert property (p_max) else $error("stall long");
  property p_len;
    $fell(cpu_stall) && !ab_q |-> cnt_q == ERASE_COUNT;
  endproperty
  a_len: assert property (p_len) else $error("stall short");
  property p_rdy;
    psel && penable |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err;
    psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c,
      8'h10}) |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("no slverr");
endmodule
bind fre_row_erase fre_chk #(.ERASE_COUNT(ERASE_COUNT)) u_fre_chk (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .abort_req(abort_req),
  .flash_req(flash_req), .cpu_stall(cpu_stall), .irq(irq));

// ### fre_pkg.sv
// Purpose: Constants and carrier types for the flash row erase control.
// Assumes: APB byte addressing, 200 MHz core clock.
// Notes: Offsets are byte addresses of 32-bit registers.
package fre_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_UNLOCK = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // Control register bit positions.
  localparam int BIT_START = 1;
  localparam int BIT_WRITE_ENABLE_BIT = 2;
  localparam int BIT_ERR = 3;
  localparam int BIT_ROW = 4;
  localparam int BIT_CFG = 6;
  localparam int BIT_MEM = 7;

  // Unlock bytes.
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;

  // Row geometry: 32 words of 16 bits, 64 bytes.
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 64;
  localparam int ROW_SHIFT = 6;
  localparam int PTR_W = 22;

  // Erase timing.
  localparam int ERASE_TIME_US = 2000;
  localparam int CLK_MHZ = 200;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [21:0] PTR_RESET = 22'h000000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Interrupt status bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;

  // Unlock sequence states.
  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_GOT_FIRST = 2'b01,
    UNL_ARMED = 2'b10
  } fre_unlock_t;

  // Erase engine states.
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_ERASE = 2'b01,
    ENG_DONE = 2'b10
  } fre_engine_t;

  // Request to the flash array.
  typedef struct packed {
    logic erase;
    logic [15:0] row;
  } fre_flash_req_t;

endpackage

// ### fre_row_erase.sv
// Purpose: Self-erase sequencer for one program flash row, APB slave.
// Assumes: Software at the registers; flash array acts on erase pulse.
// Notes: The core is stalled through the whole erase.
// Function
// R1 - Self erase covers exactly one 64-byte row.
// R2 - No single word erase is offered.
// R3 - Bulk erase is never started from software.
// R4 - Row chosen by pointer bits 21:6.
// R5 - Software prepares select, enable and row bits.
// R6 - Start accepted only after 55h then AAh.
// R7 - Start bit with valid setup begins erase.
// R8 - Core halted until the erase ends.
// R9 - Internal timer ends the erase, about 2 ms.
// R10 - Row select cleared by hardware at completion.
// R11 - Error flag set on early termination.
// R12 - Selects kept when the error occurs; a refused start write still loads them.
// R13 - Start bit set by software, cleared by hardware.
// R14 - Software masks interrupts around the unlock.
`timescale 1ns/1ps

// Register map (byte offsets, one 32-bit word each):
//   0x00 control: 7 memory select, 6 config select, 4 row erase,
//        3 error flag, 2 write enable, 1 start; other bits read 0.
//   0x04 unlock port: takes 55h then AAh; reads as 0.
//   0x08 table pointer, 22 bits; bits 21:6 pick the row.
//   0x0c interrupt status: bit 0 done, bit 1 error; write 1 to clear.
//   0x10 interrupt mask, same layout as the status.
//   Any other offset answers with pslverr and reads as 0.
// Timing: every APB access completes in its first access cycle.
// A start accepted at one edge raises the stall and the erase pulse
// at that edge; the stall then lasts ERASE_COUNT cycles unless an
// abort ends it early, which leaves the error flag set.
module fre_row_erase #(
  // Length of the erase stall in core clock cycles.
  parameter int ERASE_COUNT = fre_pkg::ERASE_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Abort of a self-timed cycle by a local reset source.
  input wire logic abort_req,
  // Flash array and core.
  output fre_pkg::fre_flash_req_t flash_req,
  output logic cpu_stall,
  output logic irq
);

  // Control fields.
  logic mem_sel_q;
  logic cfg_sel_q;
  logic row_sel_q;
  logic err_q;
  logic write_enable_bit_q;
  logic start_q;
  // Table pointer, unlock state, engine state and timer.
  logic [fre_pkg::PTR_W-1:0] ptr_q;
  fre_pkg::fre_unlock_t unl_q;
  fre_pkg::fre_engine_t eng_q;
  // Cycles left in the running erase.
  logic [31:0] timer_q;
  // Interrupt status and mask.
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;

  // Access qualifiers for the APB access phase.
  logic acc;
  logic wr_acc;
  logic start_ok;
  logic start_wr;
  logic done_evt;
  logic err_evt;
  // Accepted start and refused start attempt.
  logic start_go;
  logic bad_evt;

  // Decode a write to a given offset.
  function automatic logic wr_at(input logic [7:0] off);
    return wr_acc && (paddr == off);
  endfunction

  // Every access completes in its first access cycle.
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  // Setup is valid only for a program-memory row erase.
  assign start_ok = mem_sel_q && !cfg_sel_q && write_enable_bit_q && row_sel_q; // R5
  // A start write counts only when the unlock is armed.
  assign start_wr = wr_at(fre_pkg::OFF_CONTROL)
                    && pwdata[fre_pkg::BIT_START]
                    && (unl_q == fre_pkg::UNL_ARMED); // R6
  // Completion and early termination events.
  assign done_evt = (eng_q == fre_pkg::ENG_ERASE)
                    && (timer_q == 32'h0) && !abort_req; // R9
  // An abort in the last cycle wins over completion.
  assign err_evt = (eng_q == fre_pkg::ENG_ERASE) && abort_req; // R11
  // An accepted start needs the unlock, a valid setup and an idle engine.
  assign start_go = start_wr && start_ok
                    && (eng_q == fre_pkg::ENG_IDLE); // R7
  // A start attempt refused while the engine is idle is an improper write.
  assign bad_evt = wr_at(fre_pkg::OFF_CONTROL)
                   && pwdata[fre_pkg::BIT_START] && !start_go
                   && (eng_q == fre_pkg::ENG_IDLE); // R11

  // APB answers at once; unmapped offsets flag an error.
  // Ready is raised in the setup cycle so that it stands in the access
  // phase; the bus therefore never sees a wait state.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable
                 && !(paddr inside {fre_pkg::OFF_CONTROL,
                      fre_pkg::OFF_UNLOCK, fre_pkg::OFF_PTR,
                      fre_pkg::OFF_IRQ_STAT, fre_pkg::OFF_IRQ_MASK});
    end
  end

  // Read data is registered in the setup cycle for the access phase.
  // Reading has no side effect on any register.
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      unique case (paddr)
        fre_pkg::OFF_CONTROL: begin
          prdata <= {24'h0, mem_sel_q, cfg_sel_q, 1'b0, row_sel_q,
                     err_q, write_enable_bit_q, start_q, 1'b0};
        end
        fre_pkg::OFF_PTR: begin
          prdata <= {10'h0, ptr_q};
        end
        fre_pkg::OFF_IRQ_STAT: begin
          prdata <= {30'h0, irq_stat_q};
        end
        fre_pkg::OFF_IRQ_MASK: begin
          prdata <= {30'h0, irq_mask_q};
        end
        // The unlock port and unmapped offsets read as zero.
        default: begin
          prdata <= 32'h0;
        end
      endcase
    end
  end

  // The write-protect sequence: any other byte or register write disarms.
  // A read leaves the sequence untouched, so a poll between the two
  // unlock bytes does not disarm it.
  // Each byte is taken at the access edge of its own write.
  always_ff @(posedge mclk) begin
    if (reset) begin
      unl_q <= fre_pkg::UNL_IDLE;
    end else if (wr_at(fre_pkg::OFF_UNLOCK)) begin
      if (pwdata[7:0] == fre_pkg::UNLOCK_FIRST) begin
        unl_q <= fre_pkg::UNL_GOT_FIRST; // R6
      end else if (pwdata[7:0] == fre_pkg::UNLOCK_SECOND
                   && unl_q == fre_pkg::UNL_GOT_FIRST) begin
        unl_q <= fre_pkg::UNL_ARMED; // R6
      end else begin
        unl_q <= fre_pkg::UNL_IDLE;
      end
    end else if (wr_acc) begin
      // Any other register write consumes the armed sequence.
      unl_q <= fre_pkg::UNL_IDLE;
    end
  end

  // Table pointer, held still while an erase is running.
  // A pointer write during the stall is dropped so that the row being
  // erased cannot move under the engine.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ptr_q <= fre_pkg::PTR_RESET;
    end else if (wr_at(fre_pkg::OFF_PTR) && eng_q == fre_pkg::ENG_IDLE) begin
      ptr_q <= pwdata[fre_pkg::PTR_W-1:0];
    end
  end

  // Select, enable and row-erase bits of the control register.
  // Writes while the engine runs are ignored; the core is stalled then,
  // so only a second bus master could try.
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_sel_q <= fre_pkg::CONTROL_RESET[fre_pkg::BIT_MEM];
      cfg_sel_q <= fre_pkg::CONTROL_RESET[fre_pkg::BIT_CFG];
      row_sel_q <= fre_pkg::CONTROL_RESET[fre_pkg::BIT_ROW];
      write_enable_bit_q <= fre_pkg::CONTROL_RESET[fre_pkg::BIT_WRITE_ENABLE_BIT];
    end else if (done_evt) begin
      // Row select drops once the row is erased.
      row_sel_q <= 1'b0; // R10
    end else if (wr_at(fre_pkg::OFF_CONTROL)
                 && eng_q == fre_pkg::ENG_IDLE) begin
      // On an abort the selects keep their values; a refused start write still loads them.
      mem_sel_q <= pwdata[fre_pkg::BIT_MEM]; // R12
      cfg_sel_q <= pwdata[fre_pkg::BIT_CFG]; // R12
      row_sel_q <= pwdata[fre_pkg::BIT_ROW];
      write_enable_bit_q <= pwdata[fre_pkg::BIT_WRITE_ENABLE_BIT];
    end
  end

  // Start bit: set only by an unlocked write, cleared by hardware.
  // The bit reads back as 1 for the whole stall and drops with it.
  always_ff @(posedge mclk) begin
    if (reset) begin
      start_q <= fre_pkg::CONTROL_RESET[fre_pkg::BIT_START];
    end else if (done_evt || err_evt) begin
      start_q <= 1'b0; // R13
    end else if (start_go) begin
      // A zero written here has no effect.
      start_q <= 1'b1; // R13
    end
  end

  // Error flag: set on abort or on a start attempt refused while idle.
  // Priority: a new error beats any clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      err_q <= fre_pkg::CONTROL_RESET[fre_pkg::BIT_ERR];
    end else if (err_evt) begin
      err_q <= 1'b1; // R11
    end else if (bad_evt) begin
      // An improper start attempt counts as a terminated write.
      err_q <= 1'b1; // R11
    end else if (start_go) begin
      // A new operation begins clean and completes with the flag at 0.
      err_q <= 1'b0; // R11
    end else if (wr_at(fre_pkg::OFF_CONTROL)
                 && !pwdata[fre_pkg::BIT_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // Erase engine with its internal programming timer.
  // The timer counts down from ERASE_COUNT - 1 to zero.
  // The done state gives one idle cycle after each erase before the
  // engine will take another start.
  always_ff @(posedge mclk) begin
    if (reset) begin
      eng_q <= fre_pkg::ENG_IDLE;
      timer_q <= 32'h0;
    end else begin
      unique case (eng_q)
        fre_pkg::ENG_IDLE: begin
          if (start_go) begin
            eng_q <= fre_pkg::ENG_ERASE; // R7
            timer_q <= 32'(ERASE_COUNT - 1); // R9
          end
        end
        fre_pkg::ENG_ERASE: begin
          if (err_evt || done_evt) begin
            eng_q <= fre_pkg::ENG_DONE;
          end else begin
            timer_q <= timer_q - 32'h1; // R9
          end
        end
        fre_pkg::ENG_DONE: begin
          eng_q <= fre_pkg::ENG_IDLE;
        end
        default: begin
          eng_q <= fre_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // Flash request: one pulse naming the 64-byte row, never a word or bulk.
  // Only one row is ever named; a bulk erase has no path from here.
  // The pulse tells the array to begin; it times nothing itself.
  // The row is latched with the start so that the array sees a stable
  // address for the whole erase.
  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_req <= '0;
    end else begin
      flash_req.erase <= start_go; // R1 R2 R3
      if (start_go) begin
        // Low six pointer bits are dropped.
        flash_req.row <= ptr_q[fre_pkg::PTR_W-1:fre_pkg::ROW_SHIFT]; // R4
      end
    end
  end

  // Core stall spans the whole erase.
  // The stall drops at the edge where the engine leaves the erase
  // state, so the core resumes in the cycle after completion.
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_stall <= 1'b0;
    end else begin
      cpu_stall <= start_go
                   || (eng_q == fre_pkg::ENG_ERASE
                       && !done_evt && !err_evt); // R8
    end
  end

  // Sticky interrupt status, write one to clear; set wins.
  // Bit 0 records a completed erase, bit 1 an abort or improper start.
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_stat_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == fre_pkg::IRQ_DONE && done_evt)
            || (i == fre_pkg::IRQ_ERR && (err_evt || bad_evt))) begin
          irq_stat_q[i] <= 1'b1;
        end else if (wr_at(fre_pkg::OFF_IRQ_STAT) && pwdata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask register.
  // A zero bit keeps its status bit away from the interrupt line.
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask_q <= fre_pkg::IRQ_MASK_RESET;
    end else if (wr_at(fre_pkg::OFF_IRQ_MASK)) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  // Level interrupt output.
  // The output lags the status by one cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the flash row erase control.
// Assumes: Short erase count; APB slave answers by itself.
// Notes: Seeded random pointers with corner values among them.
`timescale 1ns/1ps
module testbench;
  localparam int EC = 20;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic abort_req = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fre_pkg::fre_flash_req_t flash_req;
  logic cpu_stall;
  logic irq;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int len;
  logic [31:0] rd;
  logic se;
  logic [15:0] row;
  fre_row_erase #(.ERASE_COUNT(EC)) u_fre_row_erase (.mclk(mclk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .abort_req(abort_req), .flash_req(flash_req),
    .cpu_stall(cpu_stall), .irq(irq));
  always #2.5 mclk = ~mclk;
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, then idles one cycle.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [15:0] row_of(input logic [21:0] p);
    return p[21:6];
  endfunction
  // Full erase request; ab raises an abort inside the stall.
  task automatic erase(input logic [21:0] p, input logic [7:0] u1,
    input logic [7:0] u2, input logic ab);
    apb(1, fre_pkg::OFF_PTR, {10'h0, p});
    apb(1, fre_pkg::OFF_CONTROL, 32'h94);
    apb(1, fre_pkg::OFF_UNLOCK, {24'h0, u1});
    apb(1, fre_pkg::OFF_UNLOCK, {24'h0, u2});
    apb(1, fre_pkg::OFF_CONTROL, 32'h96);
    len = 0;
    while (cpu_stall !== 1'b1 && len < 4) begin
      @(posedge mclk);
      len++;
    end
    row = flash_req.row;
    len = 0;
    while (cpu_stall === 1'b1 && len < 99) begin
      @(posedge mclk);
      len++;
      if (len == 3) abort_req <= ab;
    end
    abort_req <= 1'b0;
  endtask
  initial begin
    logic [21:0] p;
    p = 22'($urandom(32'hc53c));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // Reset values, unmapped address and read-only bits.
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(4 * i), 32'h0);
      if (i != 1) chk(rd, 32'h0);
    end
    apb(0, 8'h14, 32'h0);
    chk({31'h0, se}, 32'h1);
    apb(1, fre_pkg::OFF_CONTROL, 32'he5);
    apb(0, fre_pkg::OFF_CONTROL, 32'h0);
    chk(rd, 32'hc4);
    $display("test regs done");
    // Wrong unlock order is refused and flagged; irq masked then cleared.
    erase(22'($urandom), 8'haa, 8'h55, 1'b0);
    chk(len, 0);
    apb(0, fre_pkg::OFF_CONTROL, 32'h0);
    chk(rd, 32'h9c);
    chk({31'h0, irq}, 32'h0);
    apb(1, fre_pkg::OFF_IRQ_MASK, 32'h3);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    apb(1, fre_pkg::OFF_IRQ_STAT, 32'h3);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    $display("test refuse done");
    // Good erases at corner and random pointers.
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 22'h3fffff : (i == 1) ? 22'h00003f : 22'($urandom);
      erase(p, 8'h55, 8'haa, 1'b0);
      chk(row, row_of(p));
      chk(len, EC);
      apb(0, fre_pkg::OFF_CONTROL, 32'h0);
      chk(rd, 32'h84);
      chk({31'h0, irq}, 32'h1);
      apb(1, fre_pkg::OFF_IRQ_STAT, 32'h1);
    end
    $display("test erase done");
    // Abort during the stall ends it early with the flag set.
    erase(22'($urandom), 8'h55, 8'haa, 1'b1);
    chk({31'h0, len < EC}, 32'h1);
    apb(0, fre_pkg::OFF_CONTROL, 32'h0);
    chk(rd & 32'hc8, 32'h88);
    $display("test abort done");
    end_sim();
  end
endmodule
